/* File: common/slc_consts.svh */
// Constants of the serial link configuration registers and controller.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH

// ********************************************************************
// Device register port.
// ********************************************************************
`define SLC_ADDR_W 10
`define SLC_DATA_W 8

// ********************************************************************
// Device register offsets.
// ********************************************************************
`define SLC_OFF_LINK_ENABLE 10'h200
`define SLC_OFF_MODE 10'h201
`define SLC_OFF_FPM 10'h202
`define SLC_OFF_SYNC 10'h203
`define SLC_OFF_CTRL 10'h204
`define SLC_OFF_SUPPORT 10'h2F0

// ********************************************************************
// Device reset values.
// ********************************************************************
`define SLC_RST_LINK_ENABLE 1'h1
`define SLC_RST_MODE 6'h00
`define SLC_RST_FPM 8'h1F
`define SLC_RST_SYNC 1'h1
`define SLC_RST_CTRL 5'h03
`define SLC_RST_SUPPORT 2'h0

// ********************************************************************
// Field positions.
// ********************************************************************
`define SLC_MODE_MSB 5
`define SLC_CTRL_SCRAM 0
`define SLC_CTRL_FMT 1
`define SLC_CTRL_SEL_LSB 2
`define SLC_CTRL_SEL_MSB 3
`define SLC_CTRL_UPPER 4
`define SLC_SUP_CAL 0
`define SLC_SUP_TSR 1

// ********************************************************************
// Sync source codes and lane mapping.
// ********************************************************************
`define SLC_SEL_SE 2'h0
`define SLC_SEL_TS 2'h1
`define SLC_SEL_NONE 2'h2
`define SLC_UPPER_BASE 4'h4
`define SLC_UPPER_MAX_L 4'h4
`define SLC_K66_SCALE 8'h00

// ********************************************************************
// Controller software register offsets.
// ********************************************************************
`define SLC_SW_MODE 4'h0
`define SLC_SW_FPM 4'h1
`define SLC_SW_CTRL 4'h2
`define SLC_SW_LANES 4'h3
`define SLC_SW_CMD 4'h4
`define SLC_SW_SYNC 4'h5
`define SLC_SW_STATUS 4'h6
`define SLC_SW_RST_LANES 4'h1

`endif

/* File: common/slc_pkg.sv */
// Types shared by both ends of the configuration link.
// Assumes the constants header is on the include path.
`include "slc_consts.svh"

package slc_pkg;
  // Bytes on the device register port.
  typedef logic [`SLC_DATA_W-1:0] slc_byte_t;
  // Addresses on the device register port.
  typedef logic [`SLC_ADDR_W-1:0] slc_addr_t;
  // Controller sequence states.
  typedef enum logic [3:0] {
    SLC_IDLE,
    SLC_LINK_OFF,
    SLC_CAL_OFF,
    SLC_WR_MODE,
    SLC_WR_FPM,
    SLC_WR_CTRL,
    SLC_CAL_ON,
    SLC_LINK_ON
  } slc_state_t;
endpackage

/* File: common/slc_reg_if.sv */
// Register port between the controller and the configuration registers.
// Assumes both ends run on the same clock, given to them separately.
`timescale 1ns/1ps
`default_nettype none
`include "slc_consts.svh"

interface slc_reg_if;
  logic [`SLC_ADDR_W-1:0] addr;
  logic [`SLC_DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [`SLC_DATA_W-1:0] rdata;

  // The device end answers; the controller end orders.
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport ctl (output addr, output wdata, output wr, output rd, input rdata);
endinterface

`default_nettype wire

/* File: logic/slc_pin_sync.sv */
// Three-stage synchroniser for a sync pin from outside the clock domain.
// Assumes the pin is a slow level; a glitch caught by only one sample never passes.
`timescale 1ns/1ps
`default_nettype none
`include "slc_consts.svh"

module slc_pin_sync import slc_pkg::*; #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic arst_n,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  // A change is taken only once the second and third stage agree.
  wire agree = (s2 == s3);

  // ******************************************************************
  // Stages and accepted level.
  // ******************************************************************
  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        level <= s3;
      end
    end
  end
endmodule

`default_nettype wire

/* File: logic/slc_device.sv */
// Configuration registers of the serial link output of a data converter.
// Assumes a mode table outside returns lanes, E, F and coding for the
// mode code now held in the link mode register.
//
// Behaviour
// - Six-bit link mode field, reset zero.
// - Software changes mode only with enables clear.
// - Multiframe length holds frames minus one, reset 31.
// - 64B/66B modes use 256*E/F frames.
// - Length and control change only while disabled.
// - Writing zero to soft sync requests sync.
// - Soft sync works for every sync source.
// - Stuck pin releases only with source 2 or 3.
// - Normal mapping uses lanes zero to L-1.
// - Upper mapping uses lanes four to 4+L-1.
// - Upper mapping only for modes up to four lanes.
// - Sync source: pin, timestamp pair, or none.
// - Timestamp source needs the timestamp receiver enabled.
// - Sample format: offset binary or two's complement.
// - Scrambler bit enables 8B/10B scrambling, reset on.
// - 64B/66B modes always scramble.
// - Software should keep the scrambler enabled.
// - Reserved bits are written as zero.
// - Disabled link holds reset, powers down serialisers.
// - Calibration enabled before link enable.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "slc_consts.svh"

module slc_device import slc_pkg::*; #(
  parameter int LANES = 8,
  parameter int KW = 16
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic arst_n,
  slc_reg_if.dev bus,
  input wire logic single_ended_sync_pin,
  input wire logic timestamp_pair_input,
  input wire logic frame_tick,
  input wire logic [3:0] mode_lanes,
  input wire logic [3:0] mode_e,
  input wire logic [4:0] mode_f,
  input wire logic mode_uses_66b,
  output logic link_reset,
  output logic serializer_power_down,
  output logic serializer_clk_on,
  output logic [LANES-1:0] lane_enable,
  output logic [5:0] active_mode,
  output logic [KW-1:0] frames_per_multiframe,
  output logic sample_twos_complement,
  output logic scramble_on,
  output logic sync_request,
  output logic multiframe_edge,
  output logic calibration_enable,
  output logic timestamp_receiver_enable
);

  // ******************************************************************
  // Software-visible registers.
  // ******************************************************************
  logic link_enable;
  logic [5:0] link_mode_select;
  logic [7:0] frames_per_multiframe_m1;
  logic soft_sync_request;
  logic [4:0] link_control;
  logic [1:0] support_enable;

  // Captured copies that the running link uses.
  logic en_q;
  logic sh_upper;
  logic [1:0] sh_sel;
  logic sh_fmt;
  logic sh_scram;
  logic sh_66b;
  logic [3:0] sh_lanes;
  logic [KW-1:0] mf_cnt;
  logic se_level;
  logic ts_level;

  // ******************************************************************
  // Address decode.
  // ******************************************************************
  // Each register answers at one address; writes need the strobe.
  wire wr_go = ce && bus.wr;
  wire hit_en = (bus.addr == `SLC_OFF_LINK_ENABLE);
  wire hit_mode = (bus.addr == `SLC_OFF_MODE);
  wire hit_fpm = (bus.addr == `SLC_OFF_FPM);
  wire hit_sync = (bus.addr == `SLC_OFF_SYNC);
  wire hit_ctrl = (bus.addr == `SLC_OFF_CTRL);
  wire hit_sup = (bus.addr == `SLC_OFF_SUPPORT);

  // Read value; reserved bits and unmapped addresses read as zero.
  wire [7:0] rd_val =
    hit_en ? {7'h00, link_enable} :
    hit_mode ? {2'h0, link_mode_select} :
    hit_fpm ? frames_per_multiframe_m1 :
    hit_sync ? {7'h00, soft_sync_request} :
    hit_ctrl ? {3'h0, link_control} :
    hit_sup ? {6'h00, support_enable} : 8'h00;

  // ******************************************************************
  // Register writes.
  // ******************************************************************
  // Only the field bits are stored, so reserved bits stay zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_enable <= `SLC_RST_LINK_ENABLE;
      link_mode_select <= `SLC_RST_MODE;
      frames_per_multiframe_m1 <= `SLC_RST_FPM;
      soft_sync_request <= `SLC_RST_SYNC;
      link_control <= `SLC_RST_CTRL;
      support_enable <= `SLC_RST_SUPPORT;
    end else if (wr_go) begin
      if (hit_en) begin
        link_enable <= bus.wdata[0];
      end
      if (hit_mode) begin
        link_mode_select <= bus.wdata[`SLC_MODE_MSB:0];
      end
      if (hit_fpm) begin
        frames_per_multiframe_m1 <= bus.wdata;
      end
      if (hit_sync) begin
        soft_sync_request <= bus.wdata[0];
      end
      if (hit_ctrl) begin
        link_control <= bus.wdata[4:0];
      end
      if (hit_sup) begin
        support_enable <= bus.wdata[1:0];
      end
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.rdata <= 8'h00;
    end else if (ce) begin
      bus.rdata <= bus.rd ? rd_val : 8'h00;
    end
  end

  // ******************************************************************
  // Capture of the settings at link enable.
  // ******************************************************************
  // A rise of the enable takes a fresh copy of the mode, length and control settings.
  wire en_rise = link_enable && !en_q;
  // Frames per multiframe in 64B/66B coding, guarded against F of zero.
  wire [KW-1:0] k66 = KW'({mode_e, `SLC_K66_SCALE} / {7'h00, mode_f});
  wire [KW-1:0] k8b = KW'({1'b0, frames_per_multiframe_m1} + 9'h001);
  wire use_66b = mode_uses_66b && (mode_f != 5'h00);
  wire [KW-1:0] k_new = use_66b ? k66 : k8b;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= 1'b0;
      active_mode <= `SLC_RST_MODE;
      sh_upper <= 1'b0;
      sh_sel <= `SLC_SEL_SE;
      sh_fmt <= 1'b1;
      sh_scram <= 1'b1;
      sh_66b <= 1'b0;
      sh_lanes <= 4'h0;
      frames_per_multiframe <= KW'(32);
    end else if (ce) begin
      en_q <= link_enable;
      if (en_rise) begin
        active_mode <= link_mode_select;
        sh_upper <= link_control[`SLC_CTRL_UPPER];
        sh_sel <= link_control[`SLC_CTRL_SEL_MSB:`SLC_CTRL_SEL_LSB];
        sh_fmt <= link_control[`SLC_CTRL_FMT];
        sh_scram <= link_control[`SLC_CTRL_SCRAM];
        sh_66b <= mode_uses_66b;
        sh_lanes <= mode_lanes;
        frames_per_multiframe <= k_new;
      end
    end
  end

  // ******************************************************************
  // Lane mapping.
  // ******************************************************************
  // Base lane is zero or four; more than four upper lanes are undefined.
  wire [4:0] lane_base = sh_upper ? {1'b0, `SLC_UPPER_BASE} : 5'h00;
  wire [4:0] lane_top = lane_base + {1'b0, sh_lanes};
  logic [LANES-1:0] lane_on;

  // Each lane runs when it falls inside the mapped window.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_on[i] = en_q && (5'(i) >= lane_base) && (5'(i) < lane_top);
  end

  // ******************************************************************
  // Sync pins.
  // ******************************************************************
  // Both pins idle high, as the request is active low on the wire.
  slc_pin_sync #(.RESET_LEVEL(1'b1)) u_se_sync (
    .clk(clk),
    .ce(ce),
    .arst_n(arst_n),
    .pin(single_ended_sync_pin),
    .level(se_level)
  );

  slc_pin_sync #(.RESET_LEVEL(1'b1)) u_ts_sync (
    .clk(clk),
    .ce(ce),
    .arst_n(arst_n),
    .pin(timestamp_pair_input),
    .level(ts_level)
  );

  // A disabled timestamp receiver reads as an idle high pin.
  wire ts_ok = ts_level || !support_enable[`SLC_SUP_TSR];
  // Only the selected pin can request; codes two and three use none.
  wire se_req = (sh_sel == `SLC_SEL_SE) && !se_level;
  wire ts_req = (sh_sel == `SLC_SEL_TS) && !ts_ok;
  wire pin_req = se_req || ts_req;
  // The soft bit requests whatever the source.
  wire next_sync = !soft_sync_request || pin_req;

  // ******************************************************************
  // Multiframe counter.
  // ******************************************************************
  // The counter is cleared while the link is off and wraps at K-1.
  wire mf_last = (mf_cnt == frames_per_multiframe - KW'(1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mf_cnt <= '0;
      multiframe_edge <= 1'b0;
    end else if (ce) begin
      multiframe_edge <= 1'b0;
      if (!en_q) begin
        mf_cnt <= '0;
      end else if (frame_tick) begin
        mf_cnt <= mf_last ? '0 : mf_cnt + KW'(1);
        multiframe_edge <= mf_last;
      end
    end
  end

  // ******************************************************************
  // Link outputs.
  // ******************************************************************
  // Link outputs follow the captured copy one cycle after capture; sync uses the captured source, calibration and timestamp outputs the live registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_reset <= 1'b1;
      serializer_power_down <= 1'b1;
      serializer_clk_on <= 1'b0;
      lane_enable <= '0;
      sample_twos_complement <= 1'b1;
      scramble_on <= 1'b1;
      sync_request <= 1'b0;
      calibration_enable <= 1'b0;
      timestamp_receiver_enable <= 1'b0;
    end else if (ce) begin
      link_reset <= !en_q;
      serializer_power_down <= !en_q;
      serializer_clk_on <= en_q;
      lane_enable <= lane_on;
      sample_twos_complement <= sh_fmt;
      scramble_on <= sh_66b || sh_scram;
      sync_request <= next_sync;
      calibration_enable <= support_enable[`SLC_SUP_CAL];
      timestamp_receiver_enable <= support_enable[`SLC_SUP_TSR];
    end
  end
endmodule

`default_nettype wire

/* File: logic/slc_host.sv */
// Controller that programs the configuration registers in a safe order.
// Assumes software on a plain port and the device on the register port.
`timescale 1ns/1ps
`default_nettype none
`include "slc_consts.svh"

module slc_host import slc_pkg::*; (
  input wire logic clk,
  input wire logic ce,
  input wire logic arst_n,
  slc_reg_if.ctl dev,
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  output logic busy
);
  logic [5:0] st_mode;
  logic [7:0] st_fpm;
  logic [4:0] st_ctrl;
  logic [3:0] st_lanes;
  logic st_sync;
  logic sync_pend;
  logic err;
  slc_state_t state;
  slc_state_t next_state;
  slc_addr_t cmd_addr;
  slc_byte_t cmd_data;
  logic cmd_wr;

  // ******************************************************************
  // Software decode.
  // ******************************************************************
  wire sw_go = ce && sw_wr;
  wire apply = sw_go && (sw_addr == `SLC_SW_CMD) && sw_wdata[0];
  // Upper mapping is refused for more than four lanes.
  wire bad = st_ctrl[`SLC_CTRL_UPPER] && (st_lanes > `SLC_UPPER_MAX_L);
  wire start = apply && (state == SLC_IDLE) && !bad;
  wire sync_set = sw_go && (sw_addr == `SLC_SW_SYNC);
  wire sync_issue = (state == SLC_IDLE) && sync_pend && !start;
  wire ts_sel = (st_ctrl[`SLC_CTRL_SEL_MSB:`SLC_CTRL_SEL_LSB] == `SLC_SEL_TS);
  wire [7:0] status = {6'h00, err, busy};
  wire [7:0] sw_val =
    (sw_addr == `SLC_SW_MODE) ? {2'h0, st_mode} :
    (sw_addr == `SLC_SW_FPM) ? st_fpm :
    (sw_addr == `SLC_SW_CTRL) ? {3'h0, st_ctrl} :
    (sw_addr == `SLC_SW_LANES) ? {4'h0, st_lanes} :
    (sw_addr == `SLC_SW_SYNC) ? {7'h00, st_sync} :
    (sw_addr == `SLC_SW_STATUS) ? status : 8'h00;

  // ******************************************************************
  // Staged settings.
  // ******************************************************************
  // Staged values may change at any time; mode, length and control reach the device on apply, the sync value on its own write.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_mode <= `SLC_RST_MODE;
      st_fpm <= `SLC_RST_FPM;
      st_ctrl <= `SLC_RST_CTRL;
      st_lanes <= `SLC_SW_RST_LANES;
      st_sync <= `SLC_RST_SYNC;
      sync_pend <= 1'b0;
      err <= 1'b0;
      sw_rdata <= 8'h00;
    end else if (ce) begin
      if (sw_go && sw_addr == `SLC_SW_MODE) begin
        st_mode <= sw_wdata[5:0];
      end
      if (sw_go && sw_addr == `SLC_SW_FPM) begin
        st_fpm <= sw_wdata;
      end
      if (sw_go && sw_addr == `SLC_SW_CTRL) begin
        st_ctrl <= sw_wdata[4:0];
      end
      if (sw_go && sw_addr == `SLC_SW_LANES) begin
        st_lanes <= sw_wdata[3:0];
      end
      if (sync_set) begin
        st_sync <= sw_wdata[0];
      end
      // A new sync write wins over the one being issued.
      sync_pend <= sync_set || (sync_pend && !sync_issue);
      if (apply && state == SLC_IDLE) begin
        err <= bad;
      end
      sw_rdata <= sw_rd ? sw_val : 8'h00;
    end
  end

  // ******************************************************************
  // Programming sequence.
  // ******************************************************************
  // Link off, calibration off, settings, calibration on, link on.
  always_comb begin
    next_state = state;
    cmd_wr = 1'b0;
    cmd_addr = `SLC_OFF_LINK_ENABLE;
    cmd_data = 8'h00;
    unique case (state)
      SLC_IDLE: begin
        if (start) begin
          next_state = SLC_LINK_OFF;
        end else if (sync_pend) begin
          cmd_wr = 1'b1;
          cmd_addr = `SLC_OFF_SYNC;
          cmd_data = {7'h00, st_sync};
        end
      end
      SLC_LINK_OFF: begin
        cmd_wr = 1'b1;
        next_state = SLC_CAL_OFF;
      end
      SLC_CAL_OFF: begin
        cmd_wr = 1'b1;
        cmd_addr = `SLC_OFF_SUPPORT;
        next_state = SLC_WR_MODE;
      end
      SLC_WR_MODE: begin
        cmd_wr = 1'b1;
        cmd_addr = `SLC_OFF_MODE;
        cmd_data = {2'h0, st_mode};
        next_state = SLC_WR_FPM;
      end
      SLC_WR_FPM: begin
        cmd_wr = 1'b1;
        cmd_addr = `SLC_OFF_FPM;
        cmd_data = st_fpm;
        next_state = SLC_WR_CTRL;
      end
      SLC_WR_CTRL: begin
        cmd_wr = 1'b1;
        cmd_addr = `SLC_OFF_CTRL;
        cmd_data = {3'h0, st_ctrl};
        next_state = SLC_CAL_ON;
      end
      SLC_CAL_ON: begin
        cmd_wr = 1'b1;
        cmd_addr = `SLC_OFF_SUPPORT;
        cmd_data = {6'h00, ts_sel, 1'b1};
        next_state = SLC_LINK_ON;
      end
      SLC_LINK_ON: begin
        cmd_wr = 1'b1;
        cmd_data = 8'h01;
        next_state = SLC_IDLE;
      end
    endcase
  end

  // Device port signals come straight from flip-flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SLC_IDLE;
      dev.addr <= `SLC_OFF_LINK_ENABLE;
      dev.wdata <= 8'h00;
      dev.wr <= 1'b0;
      dev.rd <= 1'b0;
      busy <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      dev.addr <= cmd_addr;
      dev.wdata <= cmd_data;
      dev.wr <= cmd_wr;
      dev.rd <= 1'b0;
      busy <= (next_state != SLC_IDLE);
    end
  end
endmodule

`default_nettype wire

/* File: verif/slc_asserts.sv */
// Checker on the register port between the controller and the device.
// Assumes the bench wires it to the port signals; one clock, reset low.
`timescale 1ns/1ps
`default_nettype none
module slc_asserts import slc_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr
);
  // Tracks the last link and calibration enables written to the device.
  logic en_q;
  logic cal_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= 1'b1;
      cal_q <= 1'b0;
    end else if (wr && addr == 10'h200) begin
      en_q <= wdata[0];
    end else if (wr && addr == 10'h2F0) begin
      cal_q <= wdata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ****
  // Write order and reserved bits.
  // ****
  property p_md; wr && addr == 10'h201 |-> !en_q && !cal_q; endproperty
  a_md: assert property (p_md) else $error("mode write while on");
  property p_km; wr && addr == 10'h202 |-> !en_q; endproperty
  a_km: assert property (p_km) else $error("length write while on");
  property p_ct; wr && addr == 10'h204 |-> !en_q; endproperty
  a_ct: assert property (p_ct) else $error("control write while on");
  property p_cal; wr && addr == 10'h200 && wdata[0] |-> cal_q; endproperty
  a_cal: assert property (p_cal) else $error("enable before cal");
  property p_rm; wr && addr == 10'h201 |-> wdata[7:6] == 2'h0; endproperty
  a_rm: assert property (p_rm) else $error("mode reserved bits");
  property p_rc; wr && addr == 10'h204 |-> wdata[7:5] == 3'h0; endproperty
  a_rc: assert property (p_rc) else $error("control reserved bits");
  property p_rs; wr && addr == 10'h203 |-> wdata[7:1] == 7'h00; endproperty
  a_rs: assert property (p_rs) else $error("sync reserved bits");
  // The link is switched off, reprogrammed and switched on in one burst.
  property p_seq;
    wr && addr == 10'h200 && !wdata[0] |=> (wr && addr == 10'h2F0) ##1
      (wr && addr == 10'h201) ##1 (wr && addr == 10'h202) ##1 (wr && addr == 10'h204)
      ##1 (wr && addr == 10'h2F0 && wdata[0]) ##1 (wr && addr == 10'h200 && wdata[0]);
  endproperty
  a_seq: assert property (p_seq) else $error("bad program order");
  c_on: cover property (wr && addr == 10'h200 && wdata[0]);
  c_sync: cover property (wr && addr == 10'h203 && !wdata[0]);
  c_up: cover property (wr && addr == 10'h204 && wdata[4]);
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Bench for the controller and the device joined by their register port.
// Assumes the common and design files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb import slc_pkg::*;;
  logic clk, arst_n, ce, frame_tick, single_ended_sync_pin, timestamp_pair_input;
  logic link_reset, serializer_power_down, serializer_clk_on, sample_twos_complement;
  logic scramble_on, sync_request, multiframe_edge, calibration_enable;
  logic timestamp_receiver_enable, mode_uses_66b, sw_wr, sw_rd, busy;
  logic [15:0] frames_per_multiframe;
  logic [7:0] lane_enable, sw_wdata, sw_rdata;
  logic [5:0] active_mode, md;
  logic [4:0] mode_f;
  logic [3:0] mode_lanes, mode_e, sw_addr;
  logic [31:0] seed;
  int err_total, check_count;
  slc_reg_if bus ();
  slc_device u_slc_device (.*);
  slc_host u_slc_host (.dev(bus), .*);
  slc_asserts u_chk (.clk, .arst_n, .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr));
  // Mode table answering for the mode last handed to the controller.
  assign mode_lanes = {1'b0, md[2:0]} + 4'h1;
  assign mode_e = {2'h0, md[4:3]} + 4'h1;
  assign mode_f = {3'h0, md[1:0]} + 5'h01;
  assign mode_uses_66b = md[5];
  // Clock of 20 ns.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected frames per multiframe and lane mask.
  function automatic logic [15:0] exp_k(input logic [5:0] m, input logic [7:0] k);
    return m[5] ? 16'((m[4:3] + 3'h1) * 256 / (m[1:0] + 3'h1)) : 16'(k) + 16'h0001;
  endfunction
  function automatic logic [7:0] exp_ln(input logic [5:0] m, input logic up);
    return ((8'h01 << (m[2:0] + 4'h1)) - 8'h01) << (up ? 4 : 0);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // One software write or read; read data are settled on return.
  task automatic sw(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    {sw_addr, sw_wdata, sw_wr, sw_rd} <= {a, d, w, ~w};
    @(posedge clk);
    {sw_wr, sw_rd} <= 2'h0;
    #1;
  endtask
  task automatic apply(input logic [5:0] m, input logic [7:0] k, c, input logic ok);
    md = m;
    sw(4'h0, {2'h0, m}, 1'b1);
    sw(4'h1, k, 1'b1);
    sw(4'h2, c, 1'b1);
    sw(4'h3, {4'h0, mode_lanes}, 1'b1);
    sw(4'h4, 8'h01, 1'b1);
    repeat (5) @(posedge clk);
    #1 chk({link_reset, busy}, {ok, ok});
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Counts cycles between two multiframe edges with a frame every cycle.
  task automatic mf(input logic [15:0] k);
    int n;
    frame_tick <= 1'b1;
    for (n = 0; n < 1100 && multiframe_edge !== 1'b1; n++) @(posedge clk) #1;
    @(posedge clk) #1;
    for (n = 1; n < 1100 && multiframe_edge !== 1'b1; n++) @(posedge clk) #1;
    frame_tick <= 1'b0;
    chk(16'(n), k);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog.
  initial begin
    #1000000;
    err_total++;
    end_of_test();
  end
  // ****
  // Main sequence.
  // ****
  initial begin
    logic [31:0] r;
    logic [1:0] s;
    logic u;
    {arst_n, frame_tick, sw_wr, sw_rd, sw_addr, sw_wdata, md} = '0;
    {ce, single_ended_sync_pin, timestamp_pair_input} = 3'h7;
    seed = 32'h0000F970;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({active_mode, lane_enable}, {6'h00, exp_ln(6'h00, 1'b0)});
    chk(frames_per_multiframe, 16'h0020);
    chk({sample_twos_complement, scramble_on, sync_request}, 3'h6);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      r = i == 0 ? 32'h0014FF03 : i == 1 ? 32'h00020020 : seed;
      s = r[17:16] == 2'h3 ? 2'h2 : r[17:16];
      u = r[18] & ~r[2];
      apply(r[5:0], r[15:8], {3'h0, u, s, r[19], r[20]}, 1'b1);
      chk({active_mode, lane_enable}, {r[5:0], exp_ln(r[5:0], u)});
      chk({sample_twos_complement, scramble_on}, {r[19], r[20] | r[5]});
      chk({serializer_power_down, serializer_clk_on, calibration_enable}, 3'h3);
      chk(timestamp_receiver_enable, s == 2'h1);
      mf(exp_k(r[5:0], r[15:8]));
      chk(sync_request, 1'b0);
      sw(4'h5, 8'h00, 1'b1);
      repeat (5) @(posedge clk);
      #1 chk(sync_request, 1'b1);
      sw(4'h5, 8'h01, 1'b1);
      {single_ended_sync_pin, timestamp_pair_input} <= 2'h0;
      repeat (8) @(posedge clk);
      #1 chk(sync_request, s != 2'h2);
      // Pins released while the clock enable is low: all state must hold.
      {ce, single_ended_sync_pin, timestamp_pair_input} <= 3'h3;
      repeat (8) @(posedge clk);
      #1 chk(sync_request, s != 2'h2);
      ce <= 1'b1;
      repeat (8) @(posedge clk);
    end
    apply(6'h07, 8'h00, 8'h13, 1'b0);
    chk(active_mode, r[5:0]);
    sw(4'h6, 8'h00, 1'b0);
    chk(sw_rdata[1:0], 2'h2);
    end_of_test();
  end
endmodule
`default_nettype wire
